/* File: common/sbsp_pkg.sv */
// shared constants, types and burst-order decode for the burst sram port
package sbsp_pkg;

  // ------------------------------------------------------------
  // widths and depths
  // ------------------------------------------------------------
  localparam int LANE_BITS  = 8;  // data bits of one byte lane
  localparam int BURST_BITS = 2;  // low address bits walked by a burst
  localparam int WBUF_DEPTH = 8;  // write buffer entries

  // ------------------------------------------------------------
  // timing, in enabled clock edges
  // ------------------------------------------------------------
  localparam int DATA_LATENCY_EDGES = 2;  // address edge to data edge
  localparam int SLEEP_IGNORE_MAX_CYC = 2;  // sleep rise to inputs ignored
  localparam int SLEEP_EXIT_MIN_CYC   = 2;  // sleep fall to first command

  // ------------------------------------------------------------
  // reset values and pin levels
  // ------------------------------------------------------------
  localparam logic       ORDER_LINEAR = 1'b0;  // burst order pin low
  localparam logic [1:0] BEAT_FIRST   = 2'h0;
  localparam logic [1:0] BEAT_STEP    = 2'h1;

  // burst state, one-hot
  typedef enum logic [2:0] {
    ST_DESEL = 3'h1,
    ST_READ  = 3'h2,
    ST_WRITE = 3'h4
  } sbsp_burst_t;

  // operation carried down the pipeline, one-hot
  typedef enum logic [2:0] {
    OP_NONE  = 3'h1,
    OP_READ  = 3'h2,
    OP_WRITE = 3'h4
  } sbsp_op_t;

  // low address bits of a burst beat
  function automatic logic [1:0] sbsp_burst_low(input logic [1:0] start,
                                                input logic [1:0] beat,
                                                input logic       interleave);
    return interleave ? (start ^ beat) : 2'(start + beat);
  endfunction : sbsp_burst_low

endpackage : sbsp_pkg

/* File: core/sbsp_wbuf.sv */
// empty unit: the write buffer fifo is defined in the port file

/* File: core/sbsp_port.sv */
// synchronous pipelined burst sram port: decode, burst counter, array
//
// Notes on behaviour
// - load presets burst counter from low bits
// - order pin high: interleaved xor burst order
// - order pin low: linear burst order
// - load while unselected deselects; advance continues it
// - selected load with write high starts read
// - advance continues read, ignoring select, write
// - read with output enable high drives nothing
// - selected load, write low, strobe starts write
// - advance with strobe low writes next address
// - all strobes high stores nothing, still steps
// - each low strobe writes only its lane
// - two-lane form writes lane with parity
// - parity bit per lane, absent without parity
// - clock enable inactive freezes pipeline; write buffer still drains
// - drive only read data, enable low, awake
// - sleep pin high floats all data pins
// - sleep rise ignores inputs; controller idles
// - data pins float from power-up until read
`timescale 1ns/1ps
module sbsp_port #(
  parameter int ADDR_W = 19,
  parameter int LANES  = 4,
  parameter int PARITY = 1
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  clock_enable_n_i,
  input  wire logic                  chip_select_n_i,
  input  wire logic                  chip_select_high_true_i,
  input  wire logic                  chip_select_second_n_i,
  input  wire logic                  burst_step_or_load_i,
  input  wire logic                  write_n_i,
  input  wire logic [LANES-1:0]      byte_lane_write_n_i,
  input  wire logic                  output_enable_n_i,
  input  wire logic                  sleep_request_i,
  input  wire logic                  burst_order_i,
  input  wire logic [ADDR_W-1:0]     addr_i,
  input  wire logic [LANES*8-1:0]    data_lanes_i,
  input  wire logic [LANES-1:0]      parity_lanes_i,
  output logic      [LANES*8-1:0]    data_lanes_o,
  output logic                       data_lanes_oe_o,
  output logic      [LANES-1:0]      parity_lanes_o,
  output logic                       parity_lanes_oe_o,
  output logic                       write_space_o
);
  localparam int LW = sbsp_pkg::LANE_BITS + PARITY;
  localparam int WW = LANES * LW;
  localparam int EW = ADDR_W + LANES + WW;
  localparam int HW = ADDR_W - sbsp_pkg::BURST_BITS;

  sbsp_pkg::sbsp_burst_t st_q, st_d;
  sbsp_pkg::sbsp_op_t    s1_op_q, s1_op_d, s2_op_q, s2_op_d;
  logic [HW-1:0]         hi_q, hi_d;
  logic [1:0]            start_q, start_d, beat_q, beat_d, beat_nx;
  logic [ADDR_W-1:0]     s1_addr_q, s1_addr_d, s2_addr_q, s2_addr_d;
  logic [LANES-1:0]      s1_wen_q, s1_wen_d, s2_wen_q, s2_wen_d;
  logic                  en, sel, load;

  // a write with every strobe high stores nothing
  function automatic sbsp_pkg::sbsp_op_t write_op(input logic [LANES-1:0] strobe_n);
    return (&strobe_n) ? sbsp_pkg::OP_NONE : sbsp_pkg::OP_WRITE;
  endfunction : write_op

  // ------------------------------------------------------------
  // command decode and burst walk
  // ------------------------------------------------------------
  assign en   = !clock_enable_n_i && !sleep_request_i;
  assign sel  = !chip_select_n_i && chip_select_high_true_i && !chip_select_second_n_i;
  assign load = !burst_step_or_load_i;

  always_comb begin
    st_d      = st_q;
    hi_d      = hi_q;
    start_d   = start_q;
    beat_d    = beat_q;
    s1_op_d   = s1_op_q;
    s1_addr_d = s1_addr_q;
    s1_wen_d  = s1_wen_q;
    s2_op_d   = s2_op_q;
    s2_addr_d = s2_addr_q;
    s2_wen_d  = s2_wen_q;
    beat_nx   = 2'(beat_q + sbsp_pkg::BEAT_STEP);
    if (en) begin
      s2_op_d   = s1_op_q;
      s2_addr_d = s1_addr_q;
      s2_wen_d  = s1_wen_q;
      s1_op_d   = sbsp_pkg::OP_NONE;
      s1_wen_d  = ~byte_lane_write_n_i;
      if (load && !sel) begin
        st_d = sbsp_pkg::ST_DESEL;
      end else if (load) begin
        hi_d      = addr_i[ADDR_W-1:sbsp_pkg::BURST_BITS];
        start_d   = addr_i[1:0];
        beat_d    = sbsp_pkg::BEAT_FIRST;
        s1_addr_d = addr_i;
        if (write_n_i) begin
          st_d    = sbsp_pkg::ST_READ;
          s1_op_d = sbsp_pkg::OP_READ;
        end else begin
          st_d    = sbsp_pkg::ST_WRITE;
          s1_op_d = write_op(byte_lane_write_n_i);
        end
      end else if (st_q != sbsp_pkg::ST_DESEL) begin
        // advance: selects and write control ignored
        beat_d    = beat_nx;
        s1_addr_d = {hi_q, sbsp_pkg::sbsp_burst_low(start_q, beat_nx,
                       burst_order_i != sbsp_pkg::ORDER_LINEAR)};
        if (st_q == sbsp_pkg::ST_READ) begin
          s1_op_d = sbsp_pkg::OP_READ;
        end else begin
          s1_op_d = write_op(byte_lane_write_n_i);
        end
      end
      // a continue while deselected issues nothing
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q      <= sbsp_pkg::ST_DESEL;
      hi_q      <= '0;
      start_q   <= '0;
      beat_q    <= '0;
      s1_op_q   <= sbsp_pkg::OP_NONE;
      s1_addr_q <= '0;
      s1_wen_q  <= '0;
      s2_op_q   <= sbsp_pkg::OP_NONE;
      s2_addr_q <= '0;
      s2_wen_q  <= '0;
    end else begin
      st_q      <= st_d;
      hi_q      <= hi_d;
      start_q   <= start_d;
      beat_q    <= beat_d;
      s1_op_q   <= s1_op_d;
      s1_addr_q <= s1_addr_d;
      s1_wen_q  <= s1_wen_d;
      s2_op_q   <= s2_op_d;
      s2_addr_q <= s2_addr_d;
      s2_wen_q  <= s2_wen_d;
    end
  end

  // ------------------------------------------------------------
  // lane packing, write buffer and storage array
  // ------------------------------------------------------------
  logic [WW-1:0]    wr_word, rd_word;
  logic [LANES*8-1:0] rd_data;
  logic [LANES-1:0] rd_par;
  logic [EW-1:0]    buf_out;
  logic             push, buf_ready, drain_valid, drain_ready, data_read;
  logic [WW-1:0]    mem [2**ADDR_W];

  // one parity bit rides beside each byte lane
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    assign wr_word[l*LW +: 8]              = data_lanes_i[l*8 +: 8];
    assign rd_data[l*8 +: 8]               = rd_word[l*LW +: 8];
    if (PARITY != 0) begin : g_par
      assign wr_word[l*LW+8] = parity_lanes_i[l];
      assign rd_par[l]       = rd_word[l*LW+8];
    end else begin : g_nopar
      assign rd_par[l] = 1'b0;
    end
  end

  assign data_read   = en && (s2_op_q == sbsp_pkg::OP_READ);
  assign push        = en && (s2_op_q == sbsp_pkg::OP_WRITE);
  assign drain_ready = !data_read; // array read port wins the cycle
  assign rd_word     = mem[s2_addr_q];

  sbsp_wbuf #(
    .WIDTH (EW),
    .DEPTH (sbsp_pkg::WBUF_DEPTH)
  ) u_wbuf (
    .clk_sys_i   (clk_sys_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (push),
    .in_ready_o  (buf_ready),
    .in_data_i   ({s2_addr_q, s2_wen_q, wr_word}),
    .out_valid_o (drain_valid),
    .out_ready_i (drain_ready),
    .out_data_o  (buf_out)
  );

  // masked lane write from the buffer head
  always_ff @(posedge clk_sys_i) begin
    if (drain_valid && drain_ready) begin
      for (int l = 0; l < LANES; l++) begin
        if (buf_out[WW+l]) begin
          mem[buf_out[EW-1 -: ADDR_W]][l*LW +: LW] <= buf_out[l*LW +: LW];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // output stage
  // ------------------------------------------------------------
  logic                 rdv_q, rdv_d, drive_q, drive_d;
  logic [LANES*8-1:0]   dout_q, dout_d;
  logic [LANES-1:0]     pout_q, pout_d;

  always_comb begin
    rdv_d  = en ? data_read : rdv_q;
    dout_d = data_read ? rd_data : dout_q;
    pout_d = data_read ? rd_par : pout_q;
    drive_d = rdv_d && !output_enable_n_i && !sleep_request_i;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdv_q   <= 1'b0;
      drive_q <= 1'b0;
      dout_q  <= '0;
      pout_q  <= '0;
    end else begin
      rdv_q   <= rdv_d;
      drive_q <= drive_d;
      dout_q  <= dout_d;
      pout_q  <= pout_d;
    end
  end

  assign data_lanes_o      = dout_q;
  assign parity_lanes_o    = pout_q;
  assign data_lanes_oe_o   = drive_q;
  assign parity_lanes_oe_o = drive_q;
  assign write_space_o     = buf_ready;

  // ------------------------------------------------------------
  // assertions and covers
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  a_load_preset: assert property (en && load && sel |=>
    s1_addr_q == $past(addr_i) && beat_q == 2'h0) else $error("load did not preset burst");
  a_order_xor: assert property (en && !load && st_q != sbsp_pkg::ST_DESEL && burst_order_i
    |=> s1_addr_q[1:0] == ($past(start_q) ^ $past(beat_nx))) else $error("interleave order wrong");
  a_order_inc: assert property (en && !load && st_q != sbsp_pkg::ST_DESEL && !burst_order_i
    |=> s1_addr_q[1:0] == 2'($past(start_q) + $past(beat_nx))) else $error("linear order wrong");
  a_desel_cont: assert property (en && load && !sel ##1 en && !load
    |=> s1_op_q == sbsp_pkg::OP_NONE && st_q == sbsp_pkg::ST_DESEL) else $error("deselect broken");
  a_abort_none: assert property (en && st_q == sbsp_pkg::ST_WRITE && !load
    && (&byte_lane_write_n_i) |=> s1_op_q == sbsp_pkg::OP_NONE) else $error("abort stored");
  a_stall_hold: assert property (clock_enable_n_i |=> $stable(s1_addr_q)
    && $stable(st_q) && $stable(s2_op_q)) else $error("stall moved state");
  a_read_lat: assert property (en && load && sel && write_n_i ##1 en ##1
    (en && !output_enable_n_i && !sleep_request_i) |=> data_lanes_oe_o) else $error("read late");
  a_write_push: assert property (en && load && sel && !write_n_i && !(&byte_lane_write_n_i)
    ##1 en |=> en |-> push) else $error("write not taken at data edge");
  a_drive_cause: assert property (data_lanes_oe_o |->
    !$past(output_enable_n_i) && !$past(sleep_request_i) && rdv_q)
    else $error("drive without read");
  a_sleep_float: assert property (sleep_request_i |=> !data_lanes_oe_o)
    else $error("driving while asleep");

  c_read_burst: cover property (s2_op_q == sbsp_pkg::OP_READ [*4]);
  c_write_burst: cover property (push [*4]);
  c_buf_full: cover property (!write_space_o);
  c_sleep_drop: cover property (data_lanes_oe_o ##1 sleep_request_i ##1 !data_lanes_oe_o);

endmodule : sbsp_port

// ------------------------------------------------------------
// write buffer fifo between the port pipeline and the storage array
// ------------------------------------------------------------
module sbsp_wbuf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_b_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_q [DEPTH];
  logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [PW:0]      cnt_q, cnt_d;
  logic             room_q, room_d;
  logic             push, pop;

  // ------------------------------------------------------------
  // pointer and fill bookkeeping
  // ------------------------------------------------------------
  always_comb begin
    push   = in_valid_i && room_q;
    pop    = out_ready_i && (cnt_q != '0);
    wr_d   = push ? PW'(wr_q + 1'b1) : wr_q;
    rd_d   = pop ? PW'(rd_q + 1'b1) : rd_q;
    cnt_d  = (PW+1)'(cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
    room_d = cnt_d != (PW+1)'(DEPTH);
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_q   <= '0;
      rd_q   <= '0;
      cnt_q  <= '0;
      room_q <= 1'b1;
    end else begin
      wr_q   <= wr_d;
      rd_q   <= rd_d;
      cnt_q  <= cnt_d;
      room_q <= room_d;
    end
  end

  // storage has no reset
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      store_q[wr_q] <= in_data_i;
    end
  end

  assign in_ready_o  = room_q;
  assign out_valid_o = cnt_q != '0;
  assign out_data_o  = store_q[rd_q];

endmodule : sbsp_wbuf

/* File: core/README_unused.sv */
// intentionally empty compilation unit
`timescale 1ns/1ps

/* File: testbench/sbsp_ctrl_model.sv */
// controller model that drives burst commands into the port
`timescale 1ns/1ps
module sbsp_ctrl_model (
  input  wire logic        clk_sys_i,
  input  wire logic [36:0] rd_i,
  output logic             cke_n_o,
  output logic             cs_n_o,
  output logic             cs_hi_o,
  output logic             cs2_n_o,
  output logic             step_o,
  output logic             we_n_o,
  output logic [3:0]       bw_n_o,
  output logic             oe_n_o,
  output logic             sleep_o,
  output logic [18:0]      addr_o,
  output logic [35:0]      wd_o
);
  logic [36:0] rd [4];  // captured beats: oe, parity, data
  logic [36:0] mid;     // outputs seen three cycles into a pause

  // idle and deselected from time zero
  initial begin
    {cke_n_o, step_o, sleep_o, bw_n_o} = '0;
    {cs_n_o, cs_hi_o, we_n_o, oe_n_o} = 4'hF;
    cs2_n_o = 1'b0;
    addr_o = '0;
    wd_o = '0;
  end

  // one four-beat burst then deselect; a pause freezes the port at beat pa
  task automatic burst(input logic wr, input logic [18:0] a, input logic [3:0] bw,
                       input logic [1:0] sel, input logic oe_n, input int pa,
                       input logic nap, input logic [3:0][35:0] d);
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_sys_i);
      #2;
      if (i >= 3) rd[i-3] = rd_i;
      step_o = i inside {[1:3]};
      cs_n_o = i != 0 || sel == 2'h1;
      cs_hi_o = !(i == 0 && sel == 2'h2);
      cs2_n_o = i == 0 && sel == 2'h3;
      we_n_o = !wr;
      bw_n_o = bw;
      oe_n_o = wr | oe_n;
      addr_o = (i == 0) ? a : ~addr_o;
      wd_o = (i inside {[2:5]}) ? d[i-2] : ~wd_o;
      if (i == pa) begin
        cke_n_o = !nap;
        sleep_o = nap;
        repeat (3) @(posedge clk_sys_i);
        #2;
        mid = rd_i;
        sleep_o = 1'b0;
        cke_n_o = 1'b1;
        repeat (2) @(posedge clk_sys_i);
        #2;
        cke_n_o = 1'b0;
      end
    end
  endtask : burst
endmodule : sbsp_ctrl_model

/* File: testbench/sbsp_port_tb.sv */
// self-checking bench for the burst sram port
`timescale 1ns/1ps
module sbsp_port_tb;
  logic        clk_sys_i = 1'b0;
  logic        rst_b = 1'b0;
  logic        order = 1'b1;
  logic        oe, poe, space, cke_n, cs_n, cs_hi, cs2_n, step, we_n, oe_n, sleep;
  logic [31:0] rdata;
  logic [3:0]  rpar;
  logic [3:0]  bw_n;
  logic [18:0] addr;
  logic [35:0] wd;
  logic [35:0] mem [logic [18:0]];
  int          n_mismatch = 0;
  int          cmp_count = 0;

  // 20 MHz clock
  always #25 clk_sys_i = ~clk_sys_i;

  sbsp_port u_dut (
    .clk_sys_i               (clk_sys_i),
    .rst_b_i                 (rst_b),
    .clock_enable_n_i        (cke_n),
    .chip_select_n_i         (cs_n),
    .chip_select_high_true_i (cs_hi),
    .chip_select_second_n_i  (cs2_n),
    .burst_step_or_load_i    (step),
    .write_n_i               (we_n),
    .byte_lane_write_n_i     (bw_n),
    .output_enable_n_i       (oe_n),
    .sleep_request_i         (sleep),
    .burst_order_i           (order),
    .addr_i                  (addr),
    .data_lanes_i            (wd[31:0]),
    .parity_lanes_i          (wd[35:32]),
    .data_lanes_o            (rdata),
    .data_lanes_oe_o         (oe),
    .parity_lanes_o          (rpar),
    .parity_lanes_oe_o       (poe),
    .write_space_o           (space)
  );

  sbsp_ctrl_model u_ctrl (
    .clk_sys_i (clk_sys_i),
    .rd_i      ({oe, rpar, rdata}),
    .cke_n_o   (cke_n),
    .cs_n_o    (cs_n),
    .cs_hi_o   (cs_hi),
    .cs2_n_o   (cs2_n),
    .step_o    (step),
    .we_n_o    (we_n),
    .bw_n_o    (bw_n),
    .oe_n_o    (oe_n),
    .sleep_o   (sleep),
    .addr_o    (addr),
    .wd_o      (wd)
  );

  // compare and count
  task automatic check(input logic [36:0] seen, input logic [36:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // verdict and stop
  task automatic end_of_test();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // low address bits of beat k
  function automatic logic [1:0] beat_lo(input logic [1:0] s, input int k);
    return order ? (s ^ 2'(k)) : 2'(s + 2'(k));
  endfunction : beat_lo

  // reset for ten cycles; burst order only changes here
  task automatic do_reset(input logic ilv);
    rst_b = 1'b0;
    order = ilv;
    repeat (10) @(posedge clk_sys_i);
    #2;
    rst_b = 1'b1;
  endtask : do_reset

  // write burst and merge the expected lanes
  task automatic do_write(input logic [18:0] a, input logic [3:0] bw, input logic [35:0] s);
    logic [3:0][35:0] d;
    logic [18:0] w;
    for (int k = 0; k < 4; k++) d[k] = s ^ {9{4'(k + 1)}};
    u_ctrl.burst(1'b1, a, bw, 2'h0, 1'b1, -1, 1'b0, d);
    for (int k = 0; k < 4; k++) begin
      w = {a[18:2], beat_lo(a[1:0], k)};
      for (int l = 0; l < 4; l++) begin
        if (!bw[l]) mem[w][l*8 +: 8] = d[k][l*8 +: 8];
        if (!bw[l]) mem[w][32+l] = d[k][32+l];
      end
    end
    repeat (12) @(posedge clk_sys_i);
    #2;
  endtask : do_write

  // read burst, optionally dummy or paused, and judge every beat
  task automatic do_read(input logic [18:0] a, input logic dummy, input int pa,
                         input logic nap);
    logic [18:0] w;
    u_ctrl.burst(1'b0, a, 4'hF, 2'h0, dummy, pa, nap, '0);
    check({35'h0, poe, oe}, {35'h0, !dummy, !dummy});
    for (int k = 0; k < 4; k++) begin
      w = {a[18:2], beat_lo(a[1:0], k)};
      if (dummy) check({u_ctrl.rd[k][36], 36'h0}, 37'h0);
      else check(u_ctrl.rd[k], {1'b1, mem[w]});
    end
    if (pa >= 0 && nap) check({u_ctrl.mid[36], 36'h0}, 37'h0);
    if (pa >= 0 && !nap) check(u_ctrl.mid, {1'b1, mem[a]});
  endtask : do_read

  // outputs after reset
  task automatic t_reset_state();
    check({34'h0, poe, oe, space}, 37'h1);
  endtask : t_reset_state

  // interleaved bursts from two start positions
  task automatic t_interleave();
    do_write(19'h00120, 4'h0, 36'hA5A5A5A50);
    do_read(19'h00121, 1'b0, -1, 1'b0);
    do_read(19'h00122, 1'b0, -1, 1'b0);
  endtask : t_interleave

  // single lanes, a lane pair and an aborted write
  task automatic t_strobes();
    do_write(19'h00124, 4'h0, 36'h123456780);
    for (int l = 0; l < 4; l++) do_write(19'h00124 + 19'(l), ~(4'h1 << l), 36'hF0E1D2C3B);
    do_write(19'h00125, 4'h5, 36'h96969696A);
    do_write(19'h00126, 4'hF, 36'h0);
    do_read(19'h00127, 1'b0, -1, 1'b0);
  endtask : t_strobes

  // dummy read then a real one
  task automatic t_dummy();
    do_read(19'h00120, 1'b1, -1, 1'b0);
    do_read(19'h00123, 1'b0, -1, 1'b0);
  endtask : t_dummy

  // each select inactive on load deselects the whole burst
  task automatic t_deselect();
    for (int s = 1; s < 4; s++) begin
      u_ctrl.burst(1'b0, 19'h00120, 4'hF, 2'(s), 1'b0, -1, 1'b0, '0);
      for (int k = 0; k < 4; k++) check({u_ctrl.rd[k][36], 36'h0}, 37'h0);
    end
  endtask : t_deselect

  // clock-enable stall and sleep in mid-burst
  task automatic t_pause();
    do_read(19'h00123, 1'b0, 3, 1'b0);
    do_read(19'h00120, 1'b0, 3, 1'b1);
  endtask : t_pause

  // linear order after a second reset
  task automatic t_linear();
    do_reset(1'b0);
    t_reset_state();
    do_write(19'h00202, 4'h0, 36'h3C3C3C3C0);
    do_read(19'h00203, 1'b0, -1, 1'b0);
    check({36'h0, space}, 37'h1);
  endtask : t_linear

  // main sequence
  initial begin
    do_reset(1'b1);
    t_reset_state();
    t_interleave();
    t_strobes();
    t_dummy();
    t_deselect();
    t_pause();
    t_linear();
    end_of_test();
  end

  // watchdog against a hung run
  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end
endmodule : sbsp_port_tb
